// *** common/usb_event_map.vh ***
// Register offsets, field positions and reset values of the USB global event block
`ifndef USB_EVENT_MAP_VH
`define USB_EVENT_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define EVENT_FLAGS_ADDR 8'hBD
`define EVENT_ENABLES_ADDR 8'hBE

// ****************************************
// Field positions and masks
// ****************************************
`define BIT_SUSPEND 0
`define BIT_FRAME_START 3
`define BIT_BUS_RESET_END 4
`define BIT_RESUME_WAKE 5
`define IMPLEMENTED_MASK 8'h39

// ****************************************
// Reset values
// ****************************************
`define EVENT_FLAGS_RESET 8'h00
`define EVENT_ENABLES_RESET 8'h00

`endif

// *** hw/usb_global_event_interrupts.v ***
// USB global event flags, enables and interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "usb_event_map.vh"

module usb_global_event_interrupts (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire bus_resume_seen,
  input wire upstream_resume_active,
  input wire bus_reset_done,
  input wire frame_start_seen,
  input wire bus_suspend_seen,
  output reg usb_irq
);

  // ****************************************
  // Register file
  // ****************************************
  // One flag per global bus event; a repeated event while set is seen once by firmware
  reg [7:0] usb_event_flags;
  // One gate per flag, at the same bit position
  reg [7:0] usb_event_enables;

  // ****************************************
  // Write decode
  // ****************************************
  // Only the two mapped offsets take writes; any other address is ignored
  reg write_flags;
  reg write_enables;

  always @* begin
    write_flags = 1'b0;
    write_enables = 1'b0;
    if (reg_addr == `EVENT_FLAGS_ADDR) begin
      write_flags = reg_write;
    end else if (reg_addr == `EVENT_ENABLES_ADDR) begin
      write_enables = reg_write;
    end else begin
      write_flags = 1'b0;
      write_enables = 1'b0;
    end
  end

  // ****************************************
  // Read decode
  // ****************************************
  // Any other address reads 00
  reg read_flags;
  reg read_enables;

  always @* begin
    read_flags = 1'b0;
    read_enables = 1'b0;
    if (reg_addr == `EVENT_FLAGS_ADDR) begin
      read_flags = reg_read;
    end else if (reg_addr == `EVENT_ENABLES_ADDR) begin
      read_enables = reg_read;
    end else begin
      read_flags = 1'b0;
      read_enables = 1'b0;
    end
  end

  // ****************************************
  // Event qualification
  // ****************************************
  // Each event input is a one-cycle request to set its flag
  reg [7:0] event_set;
  wire wake_event;
  wire reset_end_event;
  wire frame_event;
  wire suspend_event;

  // Our own upstream resume also drives the bus, so it must not count as a wake-up
  assign wake_event = bus_resume_seen & ~upstream_resume_active;
  assign reset_end_event = bus_reset_done;
  assign frame_event = frame_start_seen;
  // The 3 ms idle-J timing is measured upstream; only its verdict arrives here
  assign suspend_event = bus_suspend_seen;

  always @* begin
    event_set = 8'h00;
    event_set[`BIT_RESUME_WAKE] = wake_event;
    event_set[`BIT_BUS_RESET_END] = reset_end_event;
    event_set[`BIT_FRAME_START] = frame_event;
    event_set[`BIT_SUSPEND] = suspend_event;
  end

  // ****************************************
  // Software clear
  // ****************************************
  // Writing 0 clears a flag and writing 1 leaves it, so a read-modify-write is safe
  reg [7:0] sw_clear;

  always @* begin
    sw_clear = 8'h00;
    if (write_flags) begin
      sw_clear = ~reg_wdata & `IMPLEMENTED_MASK;
    end else begin
      sw_clear = 8'h00;
    end
  end

  // ****************************************
  // Flag next values
  // ****************************************
  wire [7:0] next_flags;
  genvar i;

  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      if (((`IMPLEMENTED_MASK >> i) & 1) != 0) begin : g_used
        // Set wins over a clear in the same cycle, so an event is never lost
        assign next_flags[i] = event_set[i] | (usb_event_flags[i] & ~sw_clear[i]);
      end else begin : g_rsv
        assign next_flags[i] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Enable next values
  // ****************************************
  reg [7:0] next_enables;

  always @* begin
    next_enables = usb_event_enables;
    if (write_enables) begin
      // Reserved enable bits are dropped on write so they always read 0
      next_enables = reg_wdata & `IMPLEMENTED_MASK;
    end else begin
      next_enables = usb_event_enables;
    end
  end

  // ****************************************
  // Interrupt terms
  // ****************************************
  // New flags but old enables, so an enable write acts one cycle later
  wire wake_pending;
  wire reset_end_pending;
  wire frame_pending;
  wire suspend_pending;
  wire next_irq;

  assign wake_pending = next_flags[`BIT_RESUME_WAKE]
    & usb_event_enables[`BIT_RESUME_WAKE];
  assign reset_end_pending = next_flags[`BIT_BUS_RESET_END]
    & usb_event_enables[`BIT_BUS_RESET_END];
  assign frame_pending = next_flags[`BIT_FRAME_START]
    & usb_event_enables[`BIT_FRAME_START];
  assign suspend_pending = next_flags[`BIT_SUSPEND]
    & usb_event_enables[`BIT_SUSPEND];
  assign next_irq = wake_pending | reset_end_pending
    | frame_pending | suspend_pending;

  // ****************************************
  // Read data select
  // ****************************************
  // Unmapped addresses and idle cycles give 00, never stale data
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    if (read_flags) begin
      next_rdata = usb_event_flags & `IMPLEMENTED_MASK;
    end else if (read_enables) begin
      next_rdata = usb_event_enables & `IMPLEMENTED_MASK;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // ****************************************
  // Flag register
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usb_event_flags <= `EVENT_FLAGS_RESET;
    end else begin
      usb_event_flags <= next_flags;
    end
  end

  // ****************************************
  // Enable register
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usb_event_enables <= `EVENT_ENABLES_RESET;
    end else begin
      usb_event_enables <= next_enables;
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  // Registered so the CPU sees a glitch-free level
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usb_irq <= 1'b0;
    end else begin
      usb_irq <= next_irq;
    end
  end

endmodule
`default_nettype wire

// *** testbench/usb_event_monitor.sv ***
// Assertion checker for the USB global event block
`timescale 1ns/1ps
`default_nettype none
`include "usb_event_map.vh"
module usb_event_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic bus_resume_seen,
  input wire logic upstream_resume_active,
  input wire logic bus_reset_done,
  input wire logic frame_start_seen,
  input wire logic bus_suspend_seen,
  input wire logic usb_irq,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  reg [7:0] en;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadow of the enables, so the event checks know the gate
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n) en <= 8'h00;
    else if (reg_write && reg_addr == `EVENT_ENABLES_ADDR) en <= reg_wdata;
  property p_rsv; reg_read |=> reg_rdata[7:6] == 2'h0 && reg_rdata[2:1] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read 1");
  property p_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_rise; $rose(usb_irq) |-> $past(bus_resume_seen | bus_reset_done |
    frame_start_seen | bus_suspend_seen) || $past(reg_write, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_fall; $fell(usb_irq) |-> $past(reg_write) || $past(reg_write, 2); endproperty
  a_fall: assert property (p_fall) else $error("flag not sticky");
  property p_susp; bus_suspend_seen && en[0] |=> usb_irq; endproperty
  a_susp: assert property (p_susp) else $error("suspend irq missing");
  property p_sof; frame_start_seen && en[3] |=> usb_irq; endproperty
  a_sof: assert property (p_sof) else $error("frame irq missing");
  property p_eor; bus_reset_done && en[4] |=> usb_irq; endproperty
  a_eor: assert property (p_eor) else $error("reset end irq missing");
  property p_wake; bus_resume_seen && !upstream_resume_active && en[5] |=> usb_irq; endproperty
  a_wake: assert property (p_wake) else $error("wake irq missing");
  c_irq: cover property (usb_irq);
  c_clear: cover property ($fell(usb_irq));
  c_read: cover property (reg_read && reg_addr == `EVENT_FLAGS_ADDR);
endmodule
bind usb_global_event_interrupts usb_event_monitor mon_u (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .bus_resume_seen(bus_resume_seen),
  .upstream_resume_active(upstream_resume_active),
  .bus_reset_done(bus_reset_done),
  .frame_start_seen(frame_start_seen),
  .bus_suspend_seen(bus_suspend_seen),
  .usb_irq(usb_irq),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata)
);
`default_nettype wire

// *** testbench/usb_host_model.sv ***
// Behavioural bus side: sparse random event pulses
`timescale 1ns/1ps
`default_nettype none
module usb_host_model #(
  parameter int SEED = 32'hE6BE31EC
) (
  input wire logic clk_sys,
  output wire logic bus_resume_seen,
  output wire logic upstream_resume_active,
  output wire logic bus_reset_done,
  output wire logic frame_start_seen,
  output wire logic bus_suspend_seen
);
  // A seed apart from the bench's keeps events uncorrelated with register traffic
  integer s = SEED ^ 32'h5A5A5A5A;
  logic [4:0] ev = 5'h00;
  // Own resume overlaps bus activity at times, to exercise the mask
  assign {bus_resume_seen, upstream_resume_active, bus_reset_done, frame_start_seen,
    bus_suspend_seen} = ev;
  always @(posedge clk_sys) ev <= 5'($random(s) & $random(s) & $random(s));
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Random self-checking bench for the USB global event block
`timescale 1ns/1ps
`default_nettype none
`include "usb_event_map.vh"
module tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, usb_irq, q = 1'b0;
  logic bus_resume_seen, upstream_resume_active, bus_reset_done, frame_start_seen, bus_suspend_seen;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] f = 8'h00, e = 8'h00, rd = 8'h00;
  integer seed = 32'hE6BE31EC, n_fail = 0, comparisons = 0, cyc = 0;
  usb_host_model host_u (
    .clk_sys(clk_sys),
    .bus_resume_seen(bus_resume_seen),
    .upstream_resume_active(upstream_resume_active),
    .bus_reset_done(bus_reset_done),
    .frame_start_seen(frame_start_seen),
    .bus_suspend_seen(bus_suspend_seen)
  );
  usb_global_event_interrupts dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .bus_resume_seen(bus_resume_seen),
    .upstream_resume_active(upstream_resume_active),
    .bus_reset_done(bus_reset_done),
    .frame_start_seen(frame_start_seen),
    .bus_suspend_seen(bus_suspend_seen),
    .usb_irq(usb_irq)
  );
  initial forever #25 clk_sys = ~clk_sys;
  task check(input [7:0] seen, input [7:0] exp, input string nm);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write-0-to-clear; an event in the clearing cycle wins
  function automatic [7:0] nxt(input [7:0] cur);
    nxt = ((reg_write && reg_addr == `EVENT_FLAGS_ADDR) ? cur & reg_wdata : cur) |
      {2'h0, bus_resume_seen & ~upstream_resume_active, bus_reset_done, frame_start_seen,
      2'h0, bus_suspend_seen};
  endfunction
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n) {f, e, q, rd} <= 25'h0000000;
    else begin
      q <= |(nxt(f) & e);
      rd <= !reg_read ? 8'h00 : reg_addr == `EVENT_FLAGS_ADDR ? f :
        reg_addr == `EVENT_ENABLES_ADDR ? e : 8'h00;
      f <= nxt(f);
      if (reg_write && reg_addr == `EVENT_ENABLES_ADDR) e <= reg_wdata & `IMPLEMENTED_MASK;
    end
  // First two requests read both registers straight out of reset
  always @(posedge clk_sys) if (rst_n) begin
    cyc <= cyc + 1;
    {reg_write, reg_read} <= cyc < 2 ? 2'h1 : 2'(1 << ($random(seed) & 3));
    reg_addr <= cyc < 2 ? `EVENT_FLAGS_ADDR + 8'(cyc) : 8'hBC + 8'($random(seed) & 3);
    reg_wdata <= 8'($random(seed)) & `IMPLEMENTED_MASK;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  always @(negedge clk_sys) if (rst_n) begin
    check(reg_rdata, rd, "read data");
    check({7'h0, usb_irq}, {7'h0, q}, "irq");
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1;
    repeat (3000) @(posedge clk_sys);
    final_report;
  end
endmodule
`default_nettype wire
